// ==== hw/i3rt_defs.svh ====
// Purpose: shared constants of the read packet target
// Assumes: apb byte offsets, one 32-bit word per register
// Notes:   included by bare name
`ifndef I3RT_DEFS_SVH
`define I3RT_DEFS_SVH

`define I3RT_OFF_CTRL      12'h000
`define I3RT_OFF_IBI       12'h004
`define I3RT_OFF_STAT      12'h008
`define I3RT_OFF_ADDR      12'h00C

`define I3RT_CTRL_PEC      0
`define I3RT_CTRL_HID_LSB  1
`define I3RT_CTRL_HID_MSB  3
`define I3RT_IBI_SET       0
`define I3RT_STAT_ERR      0
`define I3RT_STAT_BUSY     1
`define I3RT_STAT_IBI      2
`define I3RT_STAT_PEC      3

`define I3RT_PEC_RST       1'b0
`define I3RT_HID_RST       3'h0

`define I3RT_BCAST_W       8'hFC
`define I3RT_NVM_LAST      10'h3FF
`define I3RT_REG_LAST      8'hFF
`define I3RT_BURST_SHORT   2
`define I3RT_BURST_LONG    16
`define I3RT_CRC_POLY      8'h07

`endif

// ==== hw/i3rt_pkg.sv ====
// Purpose: types of the read packet target
// Assumes: constants live in i3rt_defs.svh
// Notes:   no imports, use i3rt_pkg::name
package i3rt_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SEL,
        ST_SEL_ACK,
        ST_WBYTE,
        ST_WPAR,
        ST_RBYTE,
        ST_RTBIT,
        ST_IGNORE
    } i3rt_state_t;

endpackage

// ==== hw/i3rt_sync.sv ====
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to clk
// Notes:   first stage feeds only the second
module i3rt_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '1;
            q      <= '1;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule // i3rt_sync

// ==== hw/i3rt_crc8.sv ====
// Purpose: packet error code accumulator, crc-8
// Assumes: one byte folded per enable pulse
// Notes:   clear has priority over fold
`include "i3rt_defs.svh"
module i3rt_crc8 (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       clear,
    input  wire logic       fold,
    input  wire logic [7:0] data,
    output logic      [7:0] crc_q
);
    function automatic logic [7:0] step(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ({r[6:0], 1'b0} ^ `I3RT_CRC_POLY) : {r[6:0], 1'b0};
        end
        return r;
    endfunction

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_q <= 8'h00;
        end else if (clear) begin
            crc_q <= 8'h00;
        end else if (fold) begin
            crc_q <= step(crc_q, data);
        end
    end
endmodule // i3rt_crc8

// ==== hw/i3rt_target.sv ====
// Purpose: host-bus read packet target with parity, pec and ibi header
// Assumes: scl/sda asynchronous pins, rd_data valid one pclk after rd_addr
// Notes:   registers over apb, zero wait states
// Functional notes
// - bytes shift most significant bit first
// - ack own select code, nack read select on errors
// - host parity bit checked before repeated start
// - read ninth bit: one continue, zero last
// - pec off after reset
// - pec enable appends error code bytes
// - select bit one nvm, zero registers
// - register block bits are upper address
// - first byte: select, low seven address bits
// - second byte: block bits, cmd; third byte: pec byte
// - top block address bit ignored
// - nack repeated read after parity error
// - foreign select code ignored until stop/restart
// - keep nacking retries while error stands
// - zero ninth bit at last location when pec is off
// - pec covers only acknowledged select code
// - pending ibi sends own read select
// - pec excludes broadcast header byte
`include "i3rt_defs.svh"
module i3rt_target #(
    parameter logic [3:0] DEV_TYPE    = 4'h5, // arbitrary device type code
    parameter int         BURST_SHORT = `I3RT_BURST_SHORT,
    parameter int         BURST_LONG  = `I3RT_BURST_LONG
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    output logic             rd_mem_sel,
    output logic      [9:0]  rd_addr,
    input  wire logic [7:0]  rd_data
);
    i3rt_pkg::i3rt_state_t state_q;
    logic [1:0] pin_s;
    logic       scl_p_q;
    logic       sda_p_q;
    logic [2:0] bit_cnt_q;
    logic [7:0] rx_q;
    logic [1:0] wcnt_q;
    logic       ack_q;
    logic       err_q;
    logic       ibi_arb_q;
    logic       ibi_pend_q;
    logic [7:0] tx_q;
    logic [7:0] cur_q;
    logic       t_q;
    logic       pec_next_q;
    logic       pec_phase_q;
    logic [4:0] burst_cnt_q;
    logic       mem_sel_q;
    logic [9:0] addr_q;
    logic       cmd_q;
    logic       pec_en_q;
    logic [2:0] hid_q;
    logic [7:0] crc;
    logic [31:0] prdata_q;
    logic       slverr_q;

    logic       scl;
    logic       sda;
    logic       rise_ev;
    logic       fall_ev;
    logic       start_ev;
    logic       stop_ev;
    logic [7:0] rx_byte;
    logic [7:0] own_r;
    logic       sel_match;
    logic       sel_ack;
    logic       last_loc;
    logic [4:0] burst_len;
    logic       end_data;
    logic       byte_done;
    logic       crc_fold;
    logic [7:0] crc_data;

    i3rt_sync #(.WIDTH(2)) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     ({scl_i, sda_i}),
        .q     (pin_s)
    );

    assign scl = pin_s[1];
    assign sda = pin_s[0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl;
            sda_p_q <= sda;
        end
    end

    assign rise_ev   = scl & ~scl_p_q;
    assign fall_ev   = ~scl & scl_p_q;
    assign start_ev  = scl & scl_p_q & sda_p_q & ~sda;
    assign stop_ev   = scl & scl_p_q & ~sda_p_q & sda;
    assign rx_byte   = {rx_q[6:0], sda};
    assign own_r     = {DEV_TYPE, hid_q, 1'b1};
    assign sel_match = (rx_byte[7:1] == {DEV_TYPE, hid_q});
    assign sel_ack   = sel_match & ~(rx_byte[0] & err_q);
    assign last_loc  = mem_sel_q ? (addr_q == `I3RT_NVM_LAST)
                                 : (addr_q[7:0] == `I3RT_REG_LAST);
    assign burst_len = cmd_q ? 5'(BURST_LONG) : 5'(BURST_SHORT);
    assign end_data  = last_loc | (burst_cnt_q == burst_len - 5'h01);
    assign byte_done = rise_ev & (bit_cnt_q == 3'h7);

    // bit-level protocol sequencing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= i3rt_pkg::ST_IDLE;
            bit_cnt_q <= 3'h0;
            rx_q      <= 8'h00;
            ack_q     <= 1'b0;
            wcnt_q    <= 2'h0;
            ibi_arb_q <= 1'b0;
        end else if (start_ev) begin
            state_q   <= i3rt_pkg::ST_SEL;
            bit_cnt_q <= 3'h0;
            ibi_arb_q <= ibi_pend_q & (state_q == i3rt_pkg::ST_IDLE);
        end else if (stop_ev) begin
            state_q <= i3rt_pkg::ST_IDLE;
        end else if (rise_ev) begin
            unique case (state_q)
                i3rt_pkg::ST_SEL: begin
                    rx_q      <= rx_byte;
                    bit_cnt_q <= bit_cnt_q + 3'h1;
                    if (bit_cnt_q == 3'h7) begin
                        if (ibi_arb_q || !sel_match) begin
                            state_q <= i3rt_pkg::ST_IGNORE;
                        end else begin
                            state_q <= i3rt_pkg::ST_SEL_ACK;
                            ack_q   <= sel_ack;
                        end
                    end
                end
                i3rt_pkg::ST_SEL_ACK: begin
                    bit_cnt_q <= 3'h0;
                    wcnt_q    <= 2'h0;
                    if (!ack_q) begin
                        state_q <= i3rt_pkg::ST_IGNORE;
                    end else if (rx_q[0]) begin
                        state_q <= i3rt_pkg::ST_RBYTE;
                    end else begin
                        state_q <= i3rt_pkg::ST_WBYTE;
                    end
                end
                i3rt_pkg::ST_WBYTE: begin
                    rx_q      <= rx_byte;
                    bit_cnt_q <= bit_cnt_q + 3'h1;
                    if (bit_cnt_q == 3'h7) begin
                        state_q <= i3rt_pkg::ST_WPAR;
                    end
                end
                i3rt_pkg::ST_WPAR: begin
                    state_q <= i3rt_pkg::ST_WBYTE;
                    if (wcnt_q != 2'h3) begin
                        wcnt_q <= wcnt_q + 2'h1;
                    end
                end
                i3rt_pkg::ST_RBYTE: begin
                    bit_cnt_q <= bit_cnt_q + 3'h1;
                    if (bit_cnt_q == 3'h7) begin
                        state_q <= i3rt_pkg::ST_RTBIT;
                    end
                end
                i3rt_pkg::ST_RTBIT: begin
                    state_q <= t_q ? i3rt_pkg::ST_RBYTE : i3rt_pkg::ST_IGNORE;
                end
                i3rt_pkg::ST_IDLE, i3rt_pkg::ST_IGNORE: begin
                    state_q <= state_q;
                end
            endcase
        end
    end

    // address bytes and read pointer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_sel_q   <= 1'b0;
            addr_q      <= 10'h000;
            cmd_q       <= 1'b0;
            burst_cnt_q <= 5'h00;
        end else if (rise_ev && state_q == i3rt_pkg::ST_WPAR) begin
            if (wcnt_q == 2'h0) begin
                mem_sel_q   <= rx_q[7];
                addr_q[6:0] <= rx_q[6:0];
            end else if (wcnt_q == 2'h1) begin
                addr_q[9:7] <= rx_q[2:0];
                cmd_q       <= pec_en_q & rx_q[7];
            end
        end else if (rise_ev && state_q == i3rt_pkg::ST_SEL_ACK) begin
            burst_cnt_q <= 5'h00;
        end else if (byte_done && state_q == i3rt_pkg::ST_RBYTE && !pec_phase_q) begin
            burst_cnt_q <= burst_cnt_q + 5'h01;
            if (!last_loc) begin
                addr_q <= addr_q + 10'h001;
            end
        end
    end

    assign rd_mem_sel = mem_sel_q;
    assign rd_addr    = addr_q;

    // sticky fault for this transaction, dropped at stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_q <= 1'b0;
        end else if (rise_ev && state_q == i3rt_pkg::ST_WPAR &&
                     ((sda != ~(^rx_q)) ||
                      (pec_en_q && wcnt_q == 2'h2 && rx_q != crc))) begin
            err_q <= 1'b1;
        end else if (stop_ev) begin
            err_q <= 1'b0;
        end
    end

    // transmit byte, ninth bit and pec byte selection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_q        <= 8'h00;
            cur_q       <= 8'h00;
            t_q         <= 1'b0;
            pec_next_q  <= 1'b0;
            pec_phase_q <= 1'b0;
        end else if (rise_ev && state_q == i3rt_pkg::ST_SEL_ACK) begin
            tx_q        <= rd_data;
            cur_q       <= rd_data;
            pec_phase_q <= 1'b0;
        end else if (byte_done && state_q == i3rt_pkg::ST_RBYTE) begin
            t_q        <= ~pec_phase_q & (pec_en_q | ~last_loc);
            pec_next_q <= ~pec_phase_q & pec_en_q & end_data;
        end else if (rise_ev && state_q == i3rt_pkg::ST_RTBIT && t_q) begin
            tx_q        <= pec_next_q ? crc : rd_data;
            cur_q       <= pec_next_q ? crc : rd_data;
            pec_phase_q <= pec_next_q;
        end else if (fall_ev && state_q == i3rt_pkg::ST_RBYTE) begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    // crc restarts at every start, broadcast header never folded
    always_comb begin
        crc_fold = 1'b0;
        crc_data = rx_byte;
        if (byte_done && state_q == i3rt_pkg::ST_SEL) begin
            crc_fold = ~ibi_arb_q & sel_ack;
        end else if (rise_ev && state_q == i3rt_pkg::ST_WPAR) begin
            crc_fold = (wcnt_q < 2'h2);
            crc_data = rx_q;
        end else if (byte_done && state_q == i3rt_pkg::ST_RBYTE) begin
            crc_fold = ~pec_phase_q;
            crc_data = cur_q;
        end
    end

    i3rt_crc8 u_crc (
        .clk   (pclk),
        .rst_n (presetn),
        .clear (start_ev),
        .fold  (crc_fold),
        .data  (crc_data),
        .crc_q (crc)
    );

    // sda drive, set after scl falls, released at start or stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sda_o  <= 1'b0;
            sda_oe <= 1'b0;
        end else if (start_ev || stop_ev) begin
            sda_oe <= 1'b0;
        end else if (fall_ev) begin
            unique case (state_q)
                i3rt_pkg::ST_SEL: begin
                    sda_o  <= 1'b0;
                    sda_oe <= ibi_arb_q & ~own_r[3'h7 - bit_cnt_q];
                end
                i3rt_pkg::ST_SEL_ACK: begin
                    sda_o  <= 1'b0;
                    sda_oe <= ack_q;
                end
                i3rt_pkg::ST_RBYTE: begin
                    sda_o  <= tx_q[7];
                    sda_oe <= 1'b1;
                end
                i3rt_pkg::ST_RTBIT: begin
                    sda_o  <= t_q;
                    sda_oe <= 1'b1;
                end
                default: begin
                    sda_o  <= 1'b0;
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // apb slave, zero wait states
    logic setup_ph;
    logic wr_acc;
    logic mapped;

    assign setup_ph = psel & ~penable;
    assign wr_acc   = psel & penable & pwrite;
    assign mapped   = (paddr == `I3RT_OFF_CTRL) || (paddr == `I3RT_OFF_IBI) ||
                      (paddr == `I3RT_OFF_STAT) || (paddr == `I3RT_OFF_ADDR);
    assign pready   = 1'b1;
    assign prdata   = prdata_q;
    assign pslverr  = slverr_q & psel & penable;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else if (setup_ph) begin
            slverr_q <= ~mapped;
            prdata_q <= 32'h0000_0000;
            if (!pwrite) begin
                unique case (paddr)
                    `I3RT_OFF_CTRL: prdata_q <= {28'h0, hid_q, pec_en_q};
                    `I3RT_OFF_IBI:  prdata_q <= {31'h0, ibi_pend_q};
                    `I3RT_OFF_STAT: prdata_q <= {28'h0, pec_en_q, ibi_pend_q,
                                                 state_q != i3rt_pkg::ST_IDLE, err_q};
                    `I3RT_OFF_ADDR: prdata_q <= {21'h0, mem_sel_q, addr_q};
                    default:        prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pec_en_q <= `I3RT_PEC_RST;
            hid_q    <= `I3RT_HID_RST;
        end else if (wr_acc && paddr == `I3RT_OFF_CTRL) begin
            pec_en_q <= pwdata[`I3RT_CTRL_PEC];
            hid_q    <= pwdata[`I3RT_CTRL_HID_MSB:`I3RT_CTRL_HID_LSB];
        end
    end

    // software set wins over the clear on a won arbitration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ibi_pend_q <= 1'b0;
        end else if (wr_acc && paddr == `I3RT_OFF_IBI && pwdata[`I3RT_IBI_SET]) begin
            ibi_pend_q <= 1'b1;
        end else if (byte_done && state_q == i3rt_pkg::ST_SEL && ibi_arb_q &&
                     rx_byte == own_r) begin
            ibi_pend_q <= 1'b0;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_sel_done;
        byte_done && state_q == i3rt_pkg::ST_SEL && !ibi_arb_q;
    endsequence
    sequence s_rbyte_done;
        byte_done && state_q == i3rt_pkg::ST_RBYTE;
    endsequence

    a_sel_ack_low: assert property (
        fall_ev && state_q == i3rt_pkg::ST_SEL_ACK && ack_q && !start_ev && !stop_ev
        |=> sda_oe && !sda_o)
        else $error("select ack not driven low");
    a_err_nack: assert property (
        s_sel_done ##0 (sel_match && rx_byte[0] && err_q) |=> !ack_q)
        else $error("read select acked after error");
    a_foreign_ign: assert property (
        s_sel_done ##0 !sel_match |=> state_q == i3rt_pkg::ST_IGNORE)
        else $error("foreign select not ignored");
    a_ignore_hold: assert property (
        state_q == i3rt_pkg::ST_IGNORE && !start_ev && !stop_ev
        |=> state_q == i3rt_pkg::ST_IGNORE)
        else $error("ignore state left early");
    a_msb_first: assert property (
        fall_ev && state_q == i3rt_pkg::ST_RBYTE && !start_ev && !stop_ev
        |=> sda_oe && sda_o == $past(tx_q[7]) && tx_q == {$past(tx_q[6:0]), 1'b0})
        else $error("read bit not msb first");
    a_last_t0: assert property (
        s_rbyte_done ##0 (last_loc && !pec_en_q) |=> !t_q)
        else $error("last location not ended with zero");
    a_addr_inc: assert property (
        s_rbyte_done ##0 (!last_loc && !pec_phase_q) |=> addr_q == $past(addr_q) + 10'h001)
        else $error("read pointer not advanced");
    a_parity_err: assert property (
        rise_ev && state_q == i3rt_pkg::ST_WPAR && sda != ~(^rx_q) |=> err_q [*2])
        else $error("parity fault not flagged");
    a_pec_reset: assert property (
        !$past(presetn) |-> !pec_en_q)
        else $error("pec enabled out of reset");
    a_t_one_cont: assert property (
        fall_ev && state_q == i3rt_pkg::ST_RTBIT && t_q && !start_ev && !stop_ev
        |=> sda_oe && sda_o)
        else $error("continue bit not driven high");
endmodule // i3rt_target

// ==== tb/i3rt_host_model.sv ====
// Purpose: host controller model driving scl and sda
// Assumes: bench resolves sda as wired-and with a pull-up
// Notes:   scl idles high and stands still between frames
module i3rt_host_model (
    output logic      scl,
    output logic      sda_oe,
    output logic      sda_o,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        scl    = 1'b1;
        sda_oe = 1'b0;
        sda_o  = 1'b1;
    end

    task automatic bit_io(input logic drv, input logic b, output logic r);
        #200 sda_oe = drv;
        sda_o = b;
        #200 scl = 1'b1;
        r = sda;
        #400 scl = 1'b0;
    endtask

    // start from idle, or repeated start after a ninth bit
    task automatic start();
        #200 sda_oe = 1'b0;
        #200 scl = 1'b1;
        #200 sda_oe = 1'b1;
        sda_o = 1'b0;
        #200 scl = 1'b0;
    endtask

    task automatic stop();
        #200 sda_oe = 1'b1;
        sda_o = 1'b0;
        #200 scl = 1'b1;
        #200 sda_oe = 1'b0;
        #400;
    endtask

    // stops driving once a bit reads back different
    task automatic send(input logic [7:0] d, input logic drv9, input logic b9,
                        output logic [7:0] rx, output logic r9);
        logic lost;
        lost = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            bit_io(!lost, d[i], rx[i]);
            lost = lost | (rx[i] != d[i]);
        end
        bit_io(drv9, b9, r9);
    endtask

    // fin: pull sda low over a continue bit, a restart that ends the read
    task automatic recv(input logic fin, output logic [7:0] d, output logic t);
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b0, 1'b0, d[i]);
        end
        #200 sda_oe = 1'b0;
        #200 scl = 1'b1;
        t = sda;
        if (fin && t) begin
            #200 sda_oe = 1'b1;
            sda_o = 1'b0;
            #200 scl = 1'b0;
        end else begin
            #400 scl = 1'b0;
        end
    endtask
endmodule  // i3rt_host_model

// ==== tb/i3c_read_packet_target_tb.sv ====
// Purpose: self-checking bench of the read packet target
// Assumes: host model on scl/sda, memory model on rd_addr
// Notes:   random addresses from a fixed seed
`include "i3rt_defs.svh"
module i3c_read_packet_target_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [3:0] DEV = 4'h5;  // arbitrary device type code
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, ack;
    logic        scl, sda, sda_o, sda_oe, h_oe, h_o, rd_mem_sel;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [9:0]  rd_addr;
    logic [7:0]  rd_data, b1, b2, rx;
    logic [2:0]  host_id_bits;
    int          err_count, compares, seed;

    i3rt_target #(.DEV_TYPE(DEV)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .scl_i(scl), .sda_i(sda),
        .sda_o, .sda_oe, .rd_mem_sel, .rd_addr, .rd_data);
    i3rt_host_model host (.scl, .sda_oe(h_oe), .sda_o(h_o), .sda);

    assign sda = ~((sda_oe & ~sda_o) | (h_oe & ~h_o));
    assign rd_data = mem(rd_mem_sel, rd_addr);
    always #50 pclk = ~pclk;

    function automatic logic [7:0] mem(input logic s, input logic [9:0] x);
        return s ? x[7:0] ^ {x[9:8], 6'h15} : ~x[7:0];
    endfunction
    function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
        c = c ^ d;
        repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ `I3RT_CRC_POLY : {c[6:0], 1'b0};
        return c;
    endfunction
    function automatic logic [7:0] sel(input logic rw);
        return {DEV, host_id_bits, rw};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic req(input logic [7:0] a1, a2, input logic pec, bad, output logic k);
        logic [7:0] c, x;
        logic       y;
        c = crc(crc(crc(8'h00, sel(0)), a1), a2);
        host.start();
        host.send(sel(0), 1'b0, 1'b0, x, y);
        chk(y, 0);
        host.send(a1, 1'b1, ~^a1 ^ bad, x, y);
        host.send(a2, 1'b1, ~^a2, x, y);
        if (pec) host.send(c, 1'b1, ~^c, x, y);
        host.start();
        host.send(sel(1), 1'b0, 1'b0, x, k);
    endtask

    task automatic xfer(input logic [7:0] a1, a2, input logic pec, input int n);
        logic [7:0] d, c;
        logic       t, s;
        logic [9:0] a, last;
        s = a1[7];
        a = {a2[2:0], a1[6:0]};
        last = s ? `I3RT_NVM_LAST : {2'b00, `I3RT_REG_LAST};
        req(a1, a2, pec, 1'b0, t);
        chk(t, 0);
        c = crc(8'h00, sel(1));
        for (int i = 0; i < n; i++) begin
            host.recv(i == n - 1 && !pec, d, t);
            chk(d, mem(s, a));
            chk(t, pec | (a != last));
            c = crc(c, d);
            if (a == last) break;
            a = a + 10'h001;
        end
        if (pec) begin
            host.recv(1'b0, d, t);
            chk(d, c);
            chk(t, 0);
        end
        host.stop();
    endtask

    task automatic wrap_up();
        if (err_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #3000000;
        err_count++;
        wrap_up();
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        err_count = 0;
        compares = 0;
        seed = 32'h2EEBDCDA;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `I3RT_OFF_CTRL, 32'h0);
        chk(r, 0);
        apb(1'b0, 12'h010, 32'h0);
        chk(e, 1);
        host_id_bits = 3'($random(seed));
        apb(1'b1, `I3RT_OFF_CTRL, {28'h0, host_id_bits, 1'b0});
        for (int i = 0; i < 6; i++) begin
            b1 = 8'($random(seed));
            b2 = 8'($random(seed)) & (b1[7] ? 8'h0F : 8'h01);
            xfer(b1, b2, 1'b0, 1 + i % 4);
        end
        xfer(8'hFE, 8'h0F, 1'b0, 4);
        xfer(8'h7F, 8'h01, 1'b0, 2);
        apb(1'b0, `I3RT_OFF_ADDR, 32'h0);
        chk(r, 32'h0000_00FF);
        req(8'h80, 8'h00, 1'b0, 1'b1, ack);
        chk(ack, 1);
        host.start();
        host.send(sel(1), 1'b0, 1'b0, rx, ack);
        chk(ack, 1);
        host.stop();
        // foreign select, bad parity ignored, then repeated start
        host.start();
        host.send({DEV, ~host_id_bits, 1'b0}, 1'b0, 1'b0, rx, ack);
        chk(ack, 1);
        host.send(8'h00, 1'b1, 1'b0, rx, ack);
        xfer(8'hC5, 8'h03, 1'b0, 3);
        apb(1'b1, `I3RT_OFF_IBI, 32'h1);
        host.start();
        host.send(`I3RT_BCAST_W, 1'b0, 1'b0, rx, ack);
        chk(rx, sel(1));
        host.stop();
        apb(1'b0, `I3RT_OFF_STAT, 32'h0);
        chk(r[`I3RT_STAT_IBI], 0);
        apb(1'b1, `I3RT_OFF_CTRL, {28'h0, host_id_bits, 1'b1});
        for (int k = 0; k < 2; k++) begin
            host.start();
            host.send(`I3RT_BCAST_W, 1'b0, 1'b0, rx, ack);
            chk(ack, 1);
            xfer(8'h85, {k[0], 7'h42}, 1'b1, k ? `I3RT_BURST_LONG : `I3RT_BURST_SHORT);
        end
        wrap_up();
    end
endmodule  // i3c_read_packet_target_tb
